// ---- logic/wkev_pkg.sv ----
// shared constants and types for the wake event enable controller
package wkev_pkg;
    // register byte offsets
    localparam logic [7:0] PM_CTRL_OFS   = 8'h00;  // power_mgmt_control
    localparam logic [7:0] WAKE_CS1_OFS  = 8'h04;  // wake_control_status_1
    localparam logic [7:0] RX_FILT_OFS   = 8'h08;  // rx_filter_control
    localparam logic [7:0] WAKE_SRC_OFS  = 8'h0C;  // wake_source_reg
    // power_mgmt_control fields
    localparam int WS_BIT0      = 0;   // wake status bit 0: phy
    localparam int WS_BIT1      = 1;   // wake status bit 1: mac
    localparam int PHY_WEN_BIT  = 2;
    localparam int LAN_WEN_BIT  = 3;
    localparam int SUSP_LSB     = 4;   // suspend_state_select [5:4]
    localparam int SUSP_REQ_BIT = 6;   // suspend signaling request
    localparam int SUSPENDED_BIT = 7;  // read only: device suspended
    // wake_control_status_1 fields
    localparam int FILT_WEN_BIT = 0;
    localparam int KEEP_WF_BIT  = 1;
    // rx_filter_control fields
    localparam int BYPASS_BIT   = 0;
    localparam int FILT_EN_LSB  = 1;   // filter rule enables [4:1]
    localparam int FILT_W       = 4;
    // wake_source_reg fields
    localparam int SRC_LINK_BIT  = 0;
    localparam int SRC_FRAME_BIT = 1;
    localparam int SRC_PATT_BIT  = 2;
    // reset values
    localparam logic [31:0] PM_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] WAKE_CS1_RST = 32'h0000_0000;
    localparam logic [31:0] RX_FILT_RST  = 32'h0000_0000;
    // suspend_state_select encodings
    typedef enum logic [1:0] {
        WKEV_LIGHT0 = 2'b00,
        WKEV_LIGHT1 = 2'b01,
        WKEV_MID2   = 2'b10,
        WKEV_DEEP3  = 2'b11
    } wkev_susp_t;
    // power state, gray along normal -> suspended -> waking
    typedef enum logic [1:0] {
        WKEV_NORMAL  = 2'b00,
        WKEV_SUSPEND = 2'b01,
        WKEV_WAKING  = 2'b11
    } wkev_state_t;
endpackage : wkev_pkg

// ---- logic/wkev_frame_qual.sv ----
// frame qualification: good-frame test and fifo store decision
`timescale 1ns/1ps
module wkev_frame_qual #(
    parameter int FILT_W = 4                    // number of filter rule enables
) (
    input  wire logic              frmDone,     // end of received frame
    input  wire logic              frmCorrupt,  // fcs or other corruption
    input  wire logic [FILT_W-1:0] frmRuleHit,  // per-rule pass from filter engine
    input  wire logic [FILT_W-1:0] ruleEn,      // enabled rules
    input  wire logic              frmIsWake,   // pattern match on this frame
    input  wire logic              bypassWake,  // bypass filter for wake frames
    output logic                   goodFrame,   // qualifies as good frame
    output logic                   wakeFrmPass  // wake frame may be stored
);
    logic rulesOk;
    // every enabled rule must pass; with no rule enabled any clean frame is good
    assign rulesOk     = &(frmRuleHit | ~ruleEn);
    assign goodFrame   = frmDone & ~frmCorrupt & rulesOk;
    // bypass skips rules, not the corruption check
    assign wakeFrmPass = frmDone & frmIsWake & ~frmCorrupt
                         & (rulesOk | bypassWake);
endmodule : wkev_frame_qual

// ---- logic/wkev_apb_regs.sv ----
// apb slave handshake and address decode
`timescale 1ns/1ps
module wkev_apb_regs (
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [7:0]  paddr,     // apb byte address
    output logic             pready,    // always ready
    output logic             pslverr,   // unmapped address
    output logic             wrStb,     // write takes effect this edge
    output logic             rdStb,     // read data taken this edge
    output logic [3:0]       regSel     // one-hot register select
);
    import wkev_pkg::*;
    logic mapped;
    // zero wait states keeps the master simple
    assign pready = 1'b1;
    always_comb begin
        regSel = 4'h0;
        if (paddr == PM_CTRL_OFS) begin
            regSel = 4'h1;
        end else if (paddr == WAKE_CS1_OFS) begin
            regSel = 4'h2;
        end else if (paddr == RX_FILT_OFS) begin
            regSel = 4'h4;
        end else if (paddr == WAKE_SRC_OFS) begin
            regSel = 4'h8;
        end
    end
    assign mapped  = |regSel;
    assign pslverr = psel & penable & ~mapped;
    assign wrStb   = psel & penable & pwrite & mapped;
    assign rdStb   = psel & penable & ~pwrite;
endmodule : wkev_apb_regs

// ---- logic/wkev_ctrl.sv ----
// wake source arming, detection and remote wake signaling
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module wkev_ctrl #(
    parameter int FILT_W = 4                         // filter rule count
) (
    input  wire logic              mclk,             // 125 MHz clock
    input  wire logic              rstn,             // async reset, active low
    input  wire logic              psel,             // apb select
    input  wire logic              penable,          // apb enable
    input  wire logic              pwrite,           // apb write
    input  wire logic [7:0]        paddr,            // apb address
    input  wire logic [31:0]       pwdata,           // apb write data
    output logic [31:0]            prdata,           // apb read data
    output logic                   pready,           // apb ready
    output logic                   pslverr,          // apb error
    input  wire logic              phyIrq,           // internal phy interrupt
    input  wire logic              macWakeEvt,       // internal mac wake event
    input  wire logic              usbSuspend,       // usb suspend signaling seen
    input  wire logic              frmDone,          // end-of-frame strobe
    input  wire logic              frmCorrupt,       // frame corrupted
    input  wire logic [FILT_W-1:0] frmRuleHit,       // per-rule pass
    input  wire logic              frmIsWake,        // pattern matched frame
    output logic                   remoteWake,       // remote wake request
    output logic                   wakeEvent,        // wake event level
    output logic                   fifoWrite,        // store this frame
    output logic                   fifoWakeFlag      // wakeup-frame flag in status
);
    import wkev_pkg::*;
    // the rule-enable field spans bits four down to one of the filter register
    if (FILT_W < 1 || FILT_W > 4) begin : g_badFiltW
        $error("FILT_W must be 1..4");
    end
    //////////////////////////////////////////////////////////////////////////
    // bus strobes and frame qualifiers
    logic        wrStb;        // write lands this edge
    logic        rdStb;        // read in access phase
    logic        goodFrame;    // clean frame passing enabled rules
    logic        wakeFrmPass;  // wake frame allowed into the fifo
    logic        frameWake;    // good-frame wake source
    logic        pattWake;     // pattern wake source
    logic        deepSel;      // deep frame-wake suspend selected
    logic [3:0]  regSel;       // one-hot register select
    // flops end in _q, their next values in _d
    logic [31:0] pmCtrl_q;     // power_mgmt_control
    logic [31:0] pmCtrl_d;
    logic [31:0] wcs1_q;       // wake_control_status_1
    logic [31:0] wcs1_d;
    logic [31:0] rxf_q;        // rx_filter_control
    logic [31:0] rxf_d;
    logic [2:0]  src_q;        // wake_source_reg
    logic [2:0]  src_d;
    logic        postWake_q;   // a wake frame has been seen
    logic        postWake_d;
    logic        fifoWrite_q;  // store strobe
    logic        fifoWrite_d;
    logic        wakeFlag_q;   // wakeup-frame flag
    logic        wakeFlag_d;
    logic        rw_q;         // remote wake pulse
    logic        rw_d;
    wkev_state_t st_q;         // power state
    wkev_state_t st_d;
    wkev_apb_regs u_apb (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .pslverr (pslverr),
        .wrStb   (wrStb),
        .rdStb   (rdStb),
        .regSel  (regSel)
    );
    wkev_frame_qual #(.FILT_W(FILT_W)) u_qual (
        .frmDone     (frmDone),
        .frmCorrupt  (frmCorrupt),
        .frmRuleHit  (frmRuleHit),
        .ruleEn      (rxf_q[FILT_EN_LSB +: FILT_W]),
        .frmIsWake   (frmIsWake),
        .bypassWake  (rxf_q[BYPASS_BIT]),
        .goodFrame   (goodFrame),
        .wakeFrmPass (wakeFrmPass)
    );
    //////////////////////////////////////////////////////////////////////////
    // wake sources; frame waking needs lan wake enable clear, pattern needs it set
    // good frames only count in the deep frame-wake state; the light states
    // would otherwise wake on ordinary traffic
    assign frameWake = wcs1_q[FILT_WEN_BIT] & ~pmCtrl_q[LAN_WEN_BIT] & goodFrame
                     & deepSel;
    assign pattWake  = pmCtrl_q[LAN_WEN_BIT] & wakeFrmPass;
    // a sticky status bit with its enable wakes immediately, even if set earlier
    assign wakeEvent = (pmCtrl_q[WS_BIT0] & pmCtrl_q[PHY_WEN_BIT])
                     | (pmCtrl_q[WS_BIT1] & pmCtrl_q[LAN_WEN_BIT])
                     | (st_q == WKEV_SUSPEND & frameWake);
    assign remoteWake = rw_q;
    assign fifoWrite    = fifoWrite_q;
    assign fifoWakeFlag = wakeFlag_q;
    //////////////////////////////////////////////////////////////////////////
    // register next values; hardware set wins over software clear
    always_comb begin
        pmCtrl_d = pmCtrl_q;
        wcs1_d   = wcs1_q;
        rxf_d    = rxf_q;
        src_d    = src_q;
        if (wrStb && regSel[0]) begin
            // status bits are write-one-to-clear
            pmCtrl_d[SUSP_REQ_BIT:PHY_WEN_BIT] = pwdata[SUSP_REQ_BIT:PHY_WEN_BIT];
            if (pwdata[WS_BIT0]) pmCtrl_d[WS_BIT0] = 1'b0;
            if (pwdata[WS_BIT1]) pmCtrl_d[WS_BIT1] = 1'b0;
        end
        if (wrStb && regSel[1]) begin
            wcs1_d[KEEP_WF_BIT:FILT_WEN_BIT] = pwdata[KEEP_WF_BIT:FILT_WEN_BIT];
        end
        if (wrStb && regSel[2]) begin
            rxf_d[FILT_EN_LSB+FILT_W-1:BYPASS_BIT] = pwdata[FILT_EN_LSB+FILT_W-1:BYPASS_BIT];
        end
        if (wrStb && regSel[3]) begin
            src_d = src_q & ~pwdata[2:0];                 // write one to clear
        end
        if (phyIrq) pmCtrl_d[WS_BIT0] = 1'b1;
        if (macWakeEvt) pmCtrl_d[WS_BIT1] = 1'b1;
        if (st_q == WKEV_SUSPEND && pmCtrl_q[PHY_WEN_BIT] && pmCtrl_q[WS_BIT0]) begin
            src_d[SRC_LINK_BIT] = 1'b1;
        end
        if (st_q == WKEV_SUSPEND && frameWake) src_d[SRC_FRAME_BIT] = 1'b1;
        if (st_q == WKEV_SUSPEND && pattWake) src_d[SRC_PATT_BIT] = 1'b1;
        if (st_q == WKEV_SUSPEND && pattWake) pmCtrl_d[WS_BIT1] = 1'b1;
        pmCtrl_d[SUSPENDED_BIT] = (st_d != WKEV_NORMAL);
        if (st_d == WKEV_NORMAL && st_q != WKEV_NORMAL) pmCtrl_d[SUSP_REQ_BIT] = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////
    // power state: suspend on request plus usb suspend, leave on any wake
    always_comb begin
        st_d = st_q;
        rw_d = 1'b0;
        case (st_q)
            WKEV_NORMAL: begin
                if (pmCtrl_q[SUSP_REQ_BIT] && usbSuspend) st_d = WKEV_SUSPEND;
            end
            WKEV_SUSPEND: begin
                if (wakeEvent) begin
                    st_d = WKEV_WAKING;
                    rw_d = 1'b1;
                end
            end
            WKEV_WAKING: begin
                st_d = WKEV_NORMAL;
            end
            default: st_d = WKEV_NORMAL;
        endcase
    end
    //////////////////////////////////////////////////////////////////////////
    // fifo store decision for frames after and at the wake
    always_comb begin
        postWake_d  = postWake_q;
        fifoWrite_d = 1'b0;
        wakeFlag_d  = 1'b0;
        if (st_q == WKEV_SUSPEND && (frameWake || pattWake)) begin
            // the wake frame itself only when asked to keep it
            fifoWrite_d = wcs1_q[KEEP_WF_BIT];
            wakeFlag_d  = wcs1_q[KEEP_WF_BIT];
            postWake_d  = 1'b1;
        end else if (postWake_q && goodFrame) begin
            fifoWrite_d = 1'b1;
        end
        // deep suspend only is a frame-wake state; re-arm on entering any suspend state
        if (st_q == WKEV_NORMAL && st_d == WKEV_SUSPEND) postWake_d = 1'b0;
    end
    // suspend select decode: 11b is the deep frame-wake state
    assign deepSel = (wkev_susp_t'(pmCtrl_q[SUSP_LSB +: 2]) == WKEV_DEEP3);
    //////////////////////////////////////////////////////////////////////////
    // register flops; hardware set and software clear are resolved above
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pmCtrl_q <= PM_CTRL_RST;
            wcs1_q   <= WAKE_CS1_RST;
            rxf_q    <= RX_FILT_RST;
            src_q    <= 3'h0;
        end else begin
            pmCtrl_q <= pmCtrl_d;
            wcs1_q   <= wcs1_d;
            rxf_q    <= rxf_d;
            src_q    <= src_d;
        end
    end
    // power state flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= WKEV_NORMAL;
            rw_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rw_q <= rw_d;
        end
    end
    // fifo decision flops; the store outputs come straight from here
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            postWake_q  <= 1'b0;
            fifoWrite_q <= 1'b0;
            wakeFlag_q  <= 1'b0;
        end else begin
            postWake_q  <= postWake_d;
            fifoWrite_q <= fifoWrite_d;
            wakeFlag_q  <= wakeFlag_d;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // read mux, registered bits only
    always_comb begin
        prdata = 32'h0000_0000;
        if (rdStb && regSel[0]) begin
            prdata = pmCtrl_q;
        end else if (rdStb && regSel[1]) begin
            prdata = wcs1_q;
        end else if (rdStb && regSel[2]) begin
            prdata = rxf_q;
        end else if (rdStb && regSel[3]) begin
            prdata = {29'h0, src_q};
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // register and wake checks
    a_phy_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        phyIrq |=> pmCtrl_q[WS_BIT0])
        else $error("bit 0 cleared under phy irq");
    a_mac_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        macWakeEvt |=> pmCtrl_q[WS_BIT1])
        else $error("bit 1 cleared under mac evt");
    a_phy_wake_now: assert property (@(posedge mclk) disable iff (!rstn)
        pmCtrl_q[WS_BIT0] && pmCtrl_q[PHY_WEN_BIT] |-> wakeEvent)
        else $error("no wake with bit 0 and enable");
    a_lan_wake_now: assert property (@(posedge mclk) disable iff (!rstn)
        pmCtrl_q[WS_BIT1] && pmCtrl_q[LAN_WEN_BIT] |-> wakeEvent)
        else $error("no wake with bit 1 and enable");
    a_link_src_rec: assert property (@(posedge mclk) disable iff (!rstn)
        st_q == WKEV_SUSPEND && pmCtrl_q[PHY_WEN_BIT] && pmCtrl_q[WS_BIT0]
        |=> src_q[SRC_LINK_BIT] && remoteWake)
        else $error("link wake not recorded");
    a_wake_return: assert property (@(posedge mclk) disable iff (!rstn)
        remoteWake |=> st_q == WKEV_NORMAL)
        else $error("no return to normal");
    a_wake_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        remoteWake |=> !remoteWake)
        else $error("remote wake longer than one cycle");
    a_susp_flag: assert property (@(posedge mclk) disable iff (!rstn)
        pmCtrl_q[SUSPENDED_BIT] == (st_q != WKEV_NORMAL))
        else $error("suspended bit out of step with state");
    // frame path checks
    a_good_frame: assert property (@(posedge mclk) disable iff (!rstn)
        goodFrame |-> frmDone && !frmCorrupt && &(frmRuleHit | ~rxf_q[FILT_EN_LSB +: FILT_W]))
        else $error("good frame breaks a rule");
    a_bypass_pass: assert property (@(posedge mclk) disable iff (!rstn)
        frmDone && frmIsWake && !frmCorrupt && rxf_q[BYPASS_BIT] |-> wakeFrmPass)
        else $error("bypassed wake frame refused");
    a_deep_only: assert property (@(posedge mclk) disable iff (!rstn)
        frameWake |-> pmCtrl_q[SUSP_LSB +: 2] == 2'h3)
        else $error("good-frame wake outside deep suspend");
    a_frame_wake: assert property (@(posedge mclk) disable iff (!rstn)
        st_q == WKEV_SUSPEND && frameWake |=> remoteWake)
        else $error("good frame did not wake");
    a_patt_wake: assert property (@(posedge mclk) disable iff (!rstn)
        st_q == WKEV_SUSPEND && pattWake |-> ##[1:2] remoteWake)
        else $error("pattern frame did not wake");
    a_keep_frame: assert property (@(posedge mclk) disable iff (!rstn)
        st_q == WKEV_SUSPEND && (frameWake || pattWake)
        |=> fifoWrite == $past(wcs1_q[KEEP_WF_BIT]))
        else $error("wake frame store wrong");
    a_flag_paired: assert property (@(posedge mclk) disable iff (!rstn)
        fifoWakeFlag |-> fifoWrite)
        else $error("flag without store");
    a_post_store: assert property (@(posedge mclk) disable iff (!rstn)
        postWake_q && st_q != WKEV_SUSPEND && goodFrame |=> fifoWrite)
        else $error("post-wake frame dropped");
    a_bad_dropped: assert property (@(posedge mclk) disable iff (!rstn)
        frmDone && frmCorrupt |=> !fifoWrite)
        else $error("corrupt frame stored");
    // main scenarios
    c_link_wake: cover property (@(posedge mclk) disable iff (!rstn)
        st_q == WKEV_SUSPEND ##1 remoteWake && src_q[SRC_LINK_BIT]);
    c_frame_wake: cover property (@(posedge mclk) disable iff (!rstn)
        deepSel && frameWake && st_q == WKEV_SUSPEND);
    c_patt_store: cover property (@(posedge mclk) disable iff (!rstn)
        fifoWakeFlag ##[1:20] fifoWrite);
    c_patt_wake: cover property (@(posedge mclk) disable iff (!rstn)
        st_q == WKEV_SUSPEND && pattWake ##[1:2] remoteWake);
endmodule : wkev_ctrl

// ---- sim/wkev_usb_host.sv ----
// behavioural usb host model: suspend signaling and resume on remote wake
`timescale 1ns/1ps
module wkev_usb_host (
    input  wire logic mclk,        // device clock
    input  wire logic rstn,        // async reset, active low
    input  wire logic sleepReq,    // driver asks for suspend signaling
    input  wire logic remoteWake,  // remote wake pulse from the device
    output logic      usbSuspend   // suspend signaling on the bus
);
    logic susp_q;
    logic susp_d;
    //////////////////////////////////////////////////////////////////////////
    // suspend holds until a wake pulse; a missed pulse leaves the bus asleep
    always_comb begin
        susp_d = susp_q;
        if (sleepReq) begin
            susp_d = 1'b1;
        end
        if (remoteWake) begin
            susp_d = 1'b0;  // resume once the device signals wake
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            susp_q <= 1'b0;
        end else begin
            susp_q <= susp_d;
        end
    end
    assign usbSuspend = susp_q;
endmodule : wkev_usb_host

// ---- sim/wkev_ctrl_tb.sv ----
// self-checking testbench for the wake event controller
`timescale 1ns/1ps
module wkev_ctrl_tb;
    logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h7;
    logic        pready, pslverr, remoteWake, wakeEvent, fifoWrite, fifoWakeFlag, usbSuspend;
    logic        phyIrq = 1'b0, macWakeEvt = 1'b0, frmDone = 1'b0, frmCorrupt = 1'b0;
    logic        frmIsWake = 1'b0, sleepReq = 1'b0;
    logic [3:0]  frmRuleHit = 4'h0;
    logic [31:0] rdQ[$];
    logic        fifoQ[$];
    int          wakePend = 0, errorCnt = 0, nCompared = 0;
    always #4 mclk = ~mclk;
    wkev_ctrl dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phyIrq(phyIrq), .macWakeEvt(macWakeEvt), .usbSuspend(usbSuspend), .frmDone(frmDone),
        .frmCorrupt(frmCorrupt), .frmRuleHit(frmRuleHit), .frmIsWake(frmIsWake),
        .remoteWake(remoteWake), .wakeEvent(wakeEvent), .fifoWrite(fifoWrite),
        .fifoWakeFlag(fifoWakeFlag));
    wkev_usb_host host (.mclk(mclk), .rstn(rstn), .sleepReq(sleepReq),
        .remoteWake(remoteWake), .usbSuspend(usbSuspend));
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (e !== g) begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic reportAndStop;
        if (errorCnt == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : reportAndStop
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // apb master: hold the request until pready is sampled high, bounded wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            chk("pready", 1, 0);
            reportAndStop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic lvl(input logic e);
        @(negedge mclk);
        chk("wakeEvent", {31'h0, e}, {31'h0, wakeEvent});
        @(posedge mclk);
    endtask : lvl
    // one frame strobe; a gap cycle follows so the strobe is never reassigned
    task automatic frm(input logic c, input logic [3:0] h, input logic wk);
        @(posedge mclk);
        frmDone <= 1'b1;
        frmCorrupt <= c;
        frmRuleHit <= h;
        frmIsWake <= wk;
        @(posedge mclk);
        frmDone <= 1'b0;
        frmIsWake <= 1'b0;
    endtask : frm
    task automatic sleep;
        @(posedge mclk);
        sleepReq <= 1'b1;
        @(posedge mclk);
        sleepReq <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : sleep
    //////////////////////////////////////////////////////////////////////////
    // watcher: each result seen takes the oldest note of its kind
    always @(posedge mclk) begin
        if (rstn) begin
            if (psel && penable && pready) begin
                chk("pslverr", {31'h0, !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})},
                    {31'h0, pslverr});
            end
            if (psel && penable && pready && !pwrite) begin
                chk("prdata", (rdQ.size() > 0) ? rdQ.pop_front() : 32'hDEAD_BEEF, prdata);
            end
            if (fifoWrite === 1'b1) begin
                chk("fifoWakeFlag", (fifoQ.size() > 0) ? fifoQ.pop_front() : 1'bx, fifoWakeFlag);
            end
            if (remoteWake === 1'b1) begin
                chk("remoteWake", 1, (wakePend > 0) ? 1 : 0);
                wakePend--;
            end
        end
    end
    initial begin
        repeat (100000) @(posedge mclk);
        chk("watchdog", 0, 1);
        reportAndStop();
    end
    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        for (int a = 0; a < 5; a++) rd(8'(a * 4), 32'h0);  // unmapped 0x10 reads zero
        phyIrq <= 1'b1;
        apb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h4);
        lvl(1'b1);
        phyIrq <= 1'b0;
        apb(1'b1, 8'h00, 32'h5);
        rd(8'h00, 32'h4);
        lvl(1'b0);
        // link-change wake from both light suspend states
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, 8'h00, 32'h45 | (s << 4));
            sleep();
            wakePend++;
            phyIrq <= 1'b1;
            @(posedge mclk);
            phyIrq <= 1'b0;
            repeat (4) @(posedge mclk);
            rd(8'h0C, 32'h1);
            rd(8'h00, 32'h5 | (s << 4));
            apb(1'b1, 8'h0C, 32'h7);
        end
        apb(1'b1, 8'h00, 32'h1);
        // good-frame wake, with and without keeping the wake frame
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h08, 32'h6);
            apb(1'b1, 8'h04, (k == 0) ? 32'h3 : 32'h1);
            apb(1'b1, 8'h00, 32'h73);
            sleep();
            frm(1'b1, 4'h3, 1'b0);
            frm(1'b0, 4'h1, 1'b0);
            wakePend++;
            if (k == 0) fifoQ.push_back(1'b1);
            frm(1'b0, 4'h3, 1'b0);
            repeat (4) @(posedge mclk);
            rd(8'h0C, 32'h2);
            for (int j = 0; j < 8; j++) begin
                rnd = xs(rnd);
                if (!rnd[0] && (rnd[4:1] & 4'h3) == 4'h3) fifoQ.push_back(1'b0);
                frm(rnd[0], rnd[4:1], 1'b0);
            end
            apb(1'b1, 8'h0C, 32'h7);
        end
        // pattern wake with the wake frame bypassing the filter rules
        apb(1'b1, 8'h08, 32'h7);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h00, 32'h7B);
        sleep();
        wakePend++;
        fifoQ.push_back(1'b1);
        frm(1'b0, 4'h0, 1'b1);
        repeat (4) @(posedge mclk);
        rd(8'h0C, 32'h4);
        rd(8'h00, 32'h3A);
        apb(1'b1, 8'h00, 32'h0A);
        rd(8'h00, 32'h08);
        // mac wake event holds status bit 1 and raises wake on enable
        macWakeEvt <= 1'b1;
        apb(1'b1, 8'h00, 32'h2);
        rd(8'h00, 32'h2);
        lvl(1'b0);
        apb(1'b1, 8'h00, 32'h8);
        lvl(1'b1);
        macWakeEvt <= 1'b0;
        apb(1'b1, 8'h00, 32'h2);
        rd(8'h00, 32'h0);
        repeat (4) @(posedge mclk);
        chk("pendingReads", 0, 32'(rdQ.size()));
        chk("pendingFrames", 0, 32'(fifoQ.size()));
        chk("pendingWakes", 0, 32'(wakePend));
        reportAndStop();
    end
endmodule : wkev_ctrl_tb
